// [verilog/cmpo_pkg.sv]
// Purpose: constants and carrier types for the dual comparator output control block
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes: per-comparator registers repeat at a fixed stride
// How it works
// - comparator runs only while its on bit set
// - raw result high when noninverting input higher
// - polarity bit one inverts the presented result
// - result readable in control and shared registers
// - internal result latched every clock cycle
// - pin driven only when routed and direction output
// - hysteresis applied only while its bit set
// - sync mode latches on timer clock falling edge
// - sync latch uses the prescaled timer clock
// - result offered as timer gate source
// - enabled rising or falling edge sets flag
// - flag sticky; new edge beats software clear
// - edges seen on adjusted result even when off
// - first control: on7 result6 pol4 hys1 sync0
// - second control: rising bit1, falling bit0
package cmpo_pkg;
    localparam logic [7:0] CMPO_OFF_BASE    = 8'h00;
    localparam logic [7:0] CMPO_CMP_STRIDE  = 8'h08;
    localparam logic [7:0] CMPO_OFF_FIRST   = 8'h00;
    localparam logic [7:0] CMPO_OFF_SECOND  = 8'h04;
    localparam logic [7:0] CMPO_OFF_RESULTS = 8'h10;
    localparam logic [7:0] CMPO_OFF_STATUS  = 8'h14;
    localparam logic [7:0] CMPO_OFF_MASK    = 8'h18;

    localparam int CMPO_BIT_ON   = 7;
    localparam int CMPO_BIT_RES  = 6;
    localparam int CMPO_BIT_POL  = 4;
    localparam int CMPO_BIT_HYS  = 1;
    localparam int CMPO_BIT_SYNC = 0;
    localparam int CMPO_BIT_RISE = 1;
    localparam int CMPO_BIT_FALL = 0;

    typedef struct packed {
        logic on;
        logic pol;
        logic hys;
        logic sync;
        logic intp;
        logic intn;
    } cmpo_cfg_t;

    localparam cmpo_cfg_t CMPO_CFG_RST = '{default: 1'b0};
    localparam logic [1:0] CMPO_HTRANS_NONSEQ = 2'h2;
endpackage

// [verilog/cmpo_ctrl.sv]
// Purpose: digital control around the analog comparators: enable, polarity, sync, edges, irq
// Assumes: hclk is the instruction clock; timer clock input is already prescaled
// Notes: zero-wait AHB-Lite slave, always OKAY
`timescale 1ns/10ps
module cmpo_ctrl #(
    parameter int NCMP = 2
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    input  wire logic [NCMP-1:0]   cmp_raw,
    input  wire logic              t1_clk,
    input  wire logic [NCMP-1:0]   pin_route,
    input  wire logic [NCMP-1:0]   pin_dir_in,
    output logic [NCMP-1:0]        cmp_enable,
    output logic [NCMP-1:0]        hys_enable,
    output logic [NCMP-1:0]        timer_gate,
    output logic [NCMP-1:0]        pin_out,
    output logic [NCMP-1:0]        pin_oe_n,
    output logic                   irq
);

    // per-comparator registers repeat at a fixed stride
    function automatic logic [7:0] cmp_addr(input int idx, input logic [7:0] off);
        cmp_addr = 8'(cmpo_pkg::CMPO_OFF_BASE + idx * cmpo_pkg::CMPO_CMP_STRIDE + off);
    endfunction

    cmpo_pkg::cmpo_cfg_t cfg_q [NCMP];
    cmpo_pkg::cmpo_cfg_t cfg_d [NCMP];
    logic [NCMP-1:0] mask_q;
    logic [NCMP-1:0] mask_d;
    logic [NCMP-1:0] sync1_q;
    logic [NCMP-1:0] sync2_q;
    logic [NCMP-1:0] res_q;
    logic [NCMP-1:0] res_d;
    logic [NCMP-1:0] flag_q;
    logic [NCMP-1:0] flag_d;
    logic [NCMP-1:0] set_flag;
    logic [NCMP-1:0] clr_flag;
    logic [NCMP-1:0] gate_q;
    logic [NCMP-1:0] gate_d;
    logic [NCMP-1:0] oe_n_q;
    logic [NCMP-1:0] oe_n_d;
    logic [NCMP-1:0] en_q;
    logic [NCMP-1:0] hys_q;
    logic            t1_prev_q;
    logic            t1_fall;
    logic            irq_q;
    logic            irq_d;
    logic            wr_pend_q;
    logic            wr_pend_d;
    logic [7:0]      wr_addr_q;
    logic [7:0]      wr_addr_d;
    logic [31:0]     hrdata_q;
    logic [31:0]     hrdata_d;
    logic            acc;
    logic [31:0]     rd_word;

    // register writes, applied at the edge that ends the data phase
    always_comb begin
        for (int i = 0; i < NCMP; i++) begin
            cfg_d[i] = cfg_q[i];
            if (wr_pend_q && wr_addr_q == cmp_addr(i, cmpo_pkg::CMPO_OFF_FIRST)) begin
                cfg_d[i].on   = hwdata[cmpo_pkg::CMPO_BIT_ON];
                cfg_d[i].pol  = hwdata[cmpo_pkg::CMPO_BIT_POL];
                cfg_d[i].hys  = hwdata[cmpo_pkg::CMPO_BIT_HYS];
                cfg_d[i].sync = hwdata[cmpo_pkg::CMPO_BIT_SYNC];
            end
            if (wr_pend_q && wr_addr_q == cmp_addr(i, cmpo_pkg::CMPO_OFF_SECOND)) begin
                cfg_d[i].intp = hwdata[cmpo_pkg::CMPO_BIT_RISE];
                cfg_d[i].intn = hwdata[cmpo_pkg::CMPO_BIT_FALL];
            end
        end
        mask_d = mask_q;
        if (wr_pend_q && wr_addr_q == cmpo_pkg::CMPO_OFF_MASK) begin
            mask_d = hwdata[NCMP-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NCMP; i++) begin
                cfg_q[i] <= cmpo_pkg::CMPO_CFG_RST;
            end
            mask_q <= '0;
            en_q   <= '0;
            hys_q  <= '0;
        end else begin
            for (int i = 0; i < NCMP; i++) begin
                cfg_q[i] <= cfg_d[i];
                en_q[i]  <= cfg_d[i].on;
                hys_q[i] <= cfg_d[i].hys;
            end
            mask_q <= mask_d;
        end
    end

    // result path, edges and flags
    assign t1_fall = t1_prev_q & ~t1_clk;

    always_comb begin
        for (int i = 0; i < NCMP; i++) begin
            // a disabled comparator reads low before inversion, so on/pol toggles make edges
            res_d[i]    = (cfg_q[i].on & sync2_q[i]) ^ cfg_q[i].pol;
            set_flag[i] = (cfg_q[i].intp & res_d[i] & ~res_q[i])
                        | (cfg_q[i].intn & ~res_d[i] & res_q[i]);
            clr_flag[i] = wr_pend_q && wr_addr_q == cmpo_pkg::CMPO_OFF_STATUS && hwdata[i];
            // a new edge in the clear cycle keeps the flag, so no event is lost
            flag_d[i]   = set_flag[i] | (flag_q[i] & ~clr_flag[i]);
            // falling edge latch keeps the gate still while the timer counts on rising
            if (cfg_q[i].sync) begin
                gate_d[i] = t1_fall ? res_d[i] : gate_q[i];
            end else begin
                gate_d[i] = res_d[i];
            end
            oe_n_d[i] = ~(pin_route[i] & ~pin_dir_in[i]);
        end
        irq_d = |(flag_d & mask_d);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q   <= '0;
            sync2_q   <= '0;
            res_q     <= '0;
            flag_q    <= '0;
            gate_q    <= '0;
            oe_n_q    <= '1;
            t1_prev_q <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            sync1_q   <= cmp_raw;
            sync2_q   <= sync1_q;
            res_q     <= res_d;
            flag_q    <= flag_d;
            gate_q    <= gate_d;
            oe_n_q    <= oe_n_d;
            t1_prev_q <= t1_clk;
            irq_q     <= irq_d;
        end
    end

    // AHB-Lite slave; only the low address byte decodes, upper bits alias
    // zero wait states, so hreadyout and hresp are constant flops
    assign acc = hsel && hready && htrans == cmpo_pkg::CMPO_HTRANS_NONSEQ;

    // read data comes from next-state values so a read right after a write sees it
    always_comb begin
        rd_word = '0;
        for (int i = 0; i < NCMP; i++) begin
            if (haddr[7:0] == cmp_addr(i, cmpo_pkg::CMPO_OFF_FIRST)) begin
                rd_word[cmpo_pkg::CMPO_BIT_ON]   = cfg_d[i].on;
                rd_word[cmpo_pkg::CMPO_BIT_RES]  = res_d[i];
                rd_word[cmpo_pkg::CMPO_BIT_POL]  = cfg_d[i].pol;
                rd_word[cmpo_pkg::CMPO_BIT_HYS]  = cfg_d[i].hys;
                rd_word[cmpo_pkg::CMPO_BIT_SYNC] = cfg_d[i].sync;
            end
            if (haddr[7:0] == cmp_addr(i, cmpo_pkg::CMPO_OFF_SECOND)) begin
                rd_word[cmpo_pkg::CMPO_BIT_RISE] = cfg_d[i].intp;
                rd_word[cmpo_pkg::CMPO_BIT_FALL] = cfg_d[i].intn;
            end
        end
        if (haddr[7:0] == cmpo_pkg::CMPO_OFF_RESULTS) begin
            rd_word[NCMP-1:0] = res_d;
        end
        if (haddr[7:0] == cmpo_pkg::CMPO_OFF_STATUS) begin
            rd_word[NCMP-1:0] = flag_d;
        end
        if (haddr[7:0] == cmpo_pkg::CMPO_OFF_MASK) begin
            rd_word[NCMP-1:0] = mask_d;
        end
    end

    always_comb begin
        wr_pend_d = acc && hwrite;
        wr_addr_d = acc ? haddr[7:0] : wr_addr_q;
        hrdata_d  = (acc && !hwrite) ? rd_word : hrdata_q;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q  <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            hrdata_q  <= hrdata_d;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign hrdata     = hrdata_q;
    assign cmp_enable = en_q;
    assign hys_enable = hys_q;
    assign timer_gate = gate_q;
    assign pin_out    = gate_q;
    assign pin_oe_n   = oe_n_q;
    assign irq        = irq_q;

    // assertions; each watches registered outputs one edge after the cause
    // past depths assume the two flop synchroniser in front of the result
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    for (genvar g = 0; g < NCMP; g++) begin : g_chk
        a_off_result: assert property (
            !cfg_q[g].on |=> res_q[g] == $past(cfg_q[g].pol)
        ) else $error("disabled comparator result not equal to polarity");

        a_raw_passes: assert property (
            cfg_q[g].on && !cfg_q[g].pol |=> res_q[g] == $past(cmp_raw[g], 3)
        ) else $error("raw result not presented after sync");

        a_pol_inverts: assert property (
            cfg_q[g].on && cfg_q[g].pol |=> res_q[g] == !$past(cmp_raw[g], 3)
        ) else $error("inverted result wrong");

        a_rise_sets_flag: assert property (
            $rose(res_q[g]) && $past(cfg_q[g].intp) |-> flag_q[g]
        ) else $error("enabled rising edge did not set flag");

        a_flag_sticky: assert property (
            flag_q[g] && !clr_flag[g] |=> flag_q[g]
        ) else $error("flag dropped without a clear");

        a_set_beats_clear: assert property (
            clr_flag[g] && set_flag[g] |=> flag_q[g]
        ) else $error("edge lost against clear");

        a_sync_hold: assert property (
            cfg_q[g].sync && !t1_fall |=> $stable(timer_gate[g])
        ) else $error("synced gate moved without timer falling edge");

        a_async_gate: assert property (
            !cfg_q[g].sync |=> timer_gate[g] == res_q[g] && pin_out[g] == res_q[g]
        ) else $error("async gate does not follow result");

        a_pin_drive: assert property (
            1'b1 |=> pin_oe_n[g] == !($past(pin_route[g]) && !$past(pin_dir_in[g]))
        ) else $error("pin enable wrong");

        a_pin_idle: assert property (
            pin_dir_in[g] |=> pin_oe_n[g]
        ) else $error("input pin was driven");

        a_fall_sets_flag: assert property (
            $fell(res_q[g]) && $past(cfg_q[g].intn) |-> flag_q[g]
        ) else $error("enabled falling edge did not set flag");

        a_clear_works: assert property (
            clr_flag[g] && !set_flag[g] |=> !flag_q[g]
        ) else $error("flag survived a clear with no edge");

        a_enable_write: assert property (
            $past(wr_pend_q && wr_addr_q == cmp_addr(g, cmpo_pkg::CMPO_OFF_FIRST))
            |-> cmp_enable[g] == $past(hwdata[cmpo_pkg::CMPO_BIT_ON])
        ) else $error("enable output does not follow on bit");

        a_hys_write: assert property (
            $past(wr_pend_q && wr_addr_q == cmp_addr(g, cmpo_pkg::CMPO_OFF_FIRST))
            |-> hys_enable[g] == $past(hwdata[cmpo_pkg::CMPO_BIT_HYS])
        ) else $error("hysteresis output does not follow its bit");

        a_sync_latch: assert property (
            cfg_q[g].sync && t1_fall |=> timer_gate[g] == res_q[g]
        ) else $error("synced gate missed timer falling edge");

        a_sync_chain: assert property (
            1'b1 |=> sync2_q[g] == $past(sync1_q[g]) && sync1_q[g] == $past(cmp_raw[g])
        ) else $error("result synchroniser chain broken");

        a_ctrl_read: assert property (
            acc && !hwrite && haddr[7:0] == cmp_addr(g, cmpo_pkg::CMPO_OFF_FIRST)
            |=> hrdata[cmpo_pkg::CMPO_BIT_RES] == res_q[g]
        ) else $error("control read result bit wrong");

        a_second_zero: assert property (
            acc && !hwrite && haddr[7:0] == cmp_addr(g, cmpo_pkg::CMPO_OFF_SECOND)
            |=> hrdata[31:2] == 30'h0
        ) else $error("reserved bits of second control not zero");
    end

    a_irq_level: assert property (
        irq == |(flag_q & mask_q)
    ) else $error("interrupt level disagrees with flags and mask");

    a_mirror_read: assert property (
        acc && !hwrite && haddr[7:0] == cmpo_pkg::CMPO_OFF_RESULTS
        |=> hrdata[NCMP-1:0] == res_q && hreadyout
    ) else $error("shared result read wrong");

    a_status_read: assert property (
        acc && !hwrite && haddr[7:0] == cmpo_pkg::CMPO_OFF_STATUS
        |=> hrdata[NCMP-1:0] == flag_q
    ) else $error("status read disagrees with flags");

endmodule

// [tb/cmpo_partner.sv]
// Purpose: stand-in for the analog comparator core and the timer clock
// Assumes: lvl bit high means noninverting input above inverting input
// Notes: timer clock holds its level while stopped, like a gated source
`timescale 1ns/10ps
module cmpo_partner (
    input  wire logic       hclk,
    input  wire logic [1:0] lvl,
    input  wire logic       t1_run,
    output logic [1:0]      cmp_raw,
    output logic            t1_clk
);
    logic [1:0] div_q;

    assign cmp_raw = lvl;
    initial begin
        div_q  = 2'h0;
        t1_clk = 1'b1;
    end
    // slow enough that hclk always sees both levels
    always @(posedge hclk) begin
        if (t1_run) begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h3) begin
                t1_clk <= ~t1_clk;
            end
        end
    end
endmodule

// [tb/cmpo_ctrl_bench.sv]
// Purpose: register level tests of the comparator output control block
// Assumes: zero-wait slave, result settles a few cycles after a level change
// Notes: the master still waits on hready rather than assuming the latency
`timescale 1ns/10ps
module cmpo_ctrl_bench;
    logic        hclk, hresetn, hsel, hwrite, hready, hresp, irq, t1_clk, t1_run;
    logic [1:0]  htrans, lvl, cmp_raw, pin_route, pin_dir_in;
    logic [1:0]  cmp_enable, hys_enable, timer_gate, pin_out, pin_oe_n;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    int          n_fail, compares;

    cmpo_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .cmp_raw(cmp_raw), .t1_clk(t1_clk), .pin_route(pin_route),
        .pin_dir_in(pin_dir_in), .cmp_enable(cmp_enable), .hys_enable(hys_enable),
        .timer_gate(timer_gate), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq));
    cmpo_partner u_far (.hclk(hclk), .lvl(lvl), .t1_run(t1_run), .cmp_raw(cmp_raw),
        .t1_clk(t1_clk));

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= cmpo_pkg::CMPO_HTRANS_NONSEQ;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rdat = hrdata;
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk($sformatf("reg %h", a), rdat, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    task automatic setl(input logic [1:0] v);
        @(posedge hclk);
        lvl <= v;
        tick(6);
    endtask
    task automatic final_report();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // whole run is about two hundred cycles
    initial begin
        #200000;
        n_fail++;
        final_report();
    end
    initial begin
        {hresetn, hsel, hwrite, t1_run} = 4'h0;
        {htrans, pin_route, pin_dir_in} = 6'h0;
        {haddr, hwdata} = 64'h0;
        hsize = 3'h2;
        lvl = 2'h1;
        n_fail = 0;
        compares = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(8'(4 * i), 32'h0);
        end
        chk("oe_n", {30'h0, pin_oe_n}, 32'h3);
        chk("hresp", {31'h0, hresp}, 32'h0);
        $display("test reset done");
        wr(8'h18, 32'h3);
        wr(8'h04, 32'hff);
        rd(8'h04, 32'h3);
        wr(8'h00, 32'h82);
        tick(4);
        chk("en", {30'h0, cmp_enable}, 32'h1);
        chk("hys", {30'h0, hys_enable}, 32'h1);
        rd(8'h00, 32'hc2);
        rd(8'h10, 32'h1);
        chk("gate", {30'h0, timer_gate}, 32'h1);
        rd(8'h14, 32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(8'h18, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        rd(8'h14, 32'h1);
        wr(8'h18, 32'h3);
        wr(8'h14, 32'h1);
        rd(8'h14, 32'h0);
        wr(8'h00, 32'hff);
        tick(4);
        rd(8'h00, 32'h93);
        rd(8'h14, 32'h1);
        wr(8'h14, 32'h1);
        wr(8'h00, 32'h10);
        tick(4);
        rd(8'h00, 32'h50);
        rd(8'h14, 32'h1);
        chk("en", {30'h0, cmp_enable}, 32'h0);
        wr(8'h14, 32'h1);
        $display("test comparator 0 done");
        wr(8'h0c, 32'h2);
        wr(8'h08, 32'h80);
        setl(2'h3);
        rd(8'h14, 32'h2);
        rd(8'h10, 32'h3);
        wr(8'h14, 32'h2);
        setl(2'h1);
        rd(8'h14, 32'h0);
        @(posedge hclk);
        pin_route <= 2'h3;
        pin_dir_in <= 2'h2;
        tick(2);
        chk("oe_n", {30'h0, pin_oe_n}, 32'h2);
        chk("pin", {30'h0, pin_out}, 32'h1);
        $display("test comparator 1 done");
        // gate use goes with sync mode so the timer never sees a glitch
        wr(8'h08, 32'h81);
        setl(2'h3);
        rd(8'h10, 32'h3);
        chk("gate", {30'h0, timer_gate}, 32'h1);
        @(posedge hclk);
        t1_run <= 1'b1;
        tick(16);
        t1_run <= 1'b0;
        tick(2);
        chk("gate", {30'h0, timer_gate}, 32'h3);
        $display("test sync done");
        final_report();
    end
endmodule
